// ==== core/lugj_atten_decode.sv ====
`timescale 1ns/1ns
module lugj_atten_decode
	import lugj_pkg::*;
(
	input wire logic [7:0] cfg,
	input wire logic t1_mode,
	output lugj_atten_s dec
);

	always_comb begin
		dec.wide_limit = cfg[5];
		dec.in_tx = (cfg[4:3] == LUGJ_PLACE_TX);
		dec.in_rx = (cfg[4:3] == LUGJ_PLACE_RX);
		case (cfg[2:1])
			2'h0: dec.depth_bits = LUGJ_DEPTH_128;
			2'h1: dec.depth_bits = LUGJ_DEPTH_64;
			default: dec.depth_bits = LUGJ_DEPTH_32;
		endcase
		case ({t1_mode, cfg[0]})
			2'h0: dec.corner = LUGJ_CORNER_6P8HZ;
			2'h1: dec.corner = LUGJ_CORNER_0P9HZ;
			2'h2: dec.corner = LUGJ_CORNER_5HZ;
			default: dec.corner = LUGJ_CORNER_1P25HZ;
		endcase
	end

endmodule

// ==== core/lugj_pkg.sv ====
package lugj_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] LUGJ_ADR_ATTEN_BASE = 8'h01;
	localparam logic [7:0] LUGJ_ADR_CHAN_STEP = 8'h20;
	localparam logic [7:0] LUGJ_ADR_GLOBAL_CFG = 8'h40;
	localparam logic [7:0] LUGJ_ADR_MONITOR = 8'h60;
	localparam logic [7:0] LUGJ_ADR_IRQ_FLAGS = 8'h80;
	localparam logic [7:0] LUGJ_ADR_PIN_CTRL = 8'hA0;
	localparam logic [4:0] LUGJ_CHAN_OFS_MASK = 5'h1F;
	localparam logic [2:0] LUGJ_CHAN_SEL_LSB = 3'h5;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LUGJ_STD_BIT = 4;
	localparam int LUGJ_COPY_BIT = 3;
	localparam int LUGJ_PIN_B_LEVEL_BIT = 3;
	localparam int LUGJ_PIN_A_LEVEL_BIT = 2;
	localparam int LUGJ_PIN_B_DIR_BIT = 1;
	localparam int LUGJ_PIN_A_DIR_BIT = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] LUGJ_RST_ATTEN = 8'h00;
	localparam logic [7:0] LUGJ_RST_GLOBAL = 8'h00;
	localparam logic [7:0] LUGJ_RST_MONITOR = 8'h00;
	localparam logic [1:0] LUGJ_RST_PIN_DIR = 2'h3;
	localparam logic [1:0] LUGJ_RST_PIN_LEVEL = 2'h0;

	// ----------------------------------------
	// Decoded settings
	// ----------------------------------------
	localparam logic [1:0] LUGJ_PLACE_TX = 2'h1;
	localparam logic [1:0] LUGJ_PLACE_RX = 2'h3;
	localparam logic [7:0] LUGJ_DEPTH_128 = 8'h80;
	localparam logic [7:0] LUGJ_DEPTH_64 = 8'h40;
	localparam logic [7:0] LUGJ_DEPTH_32 = 8'h20;

	typedef enum logic [2:0] {
		LUGJ_CORNER_5HZ = 3'h1,
		LUGJ_CORNER_1P25HZ = 3'h2,
		LUGJ_CORNER_6P8HZ = 3'h3,
		LUGJ_CORNER_0P9HZ = 3'h4
	} lugj_corner_e;

	typedef struct packed {
		logic in_tx;
		logic in_rx;
		logic [7:0] depth_bits;
		logic wide_limit;
		lugj_corner_e corner;
	} lugj_atten_s;

	typedef struct packed {
		logic active;
		logic is_tx;
		logic [2:0] chan;
	} lugj_watch_s;

endpackage

// ==== core/lugj_regs.sv ====
`timescale 1ns/1ns
// Overview of operation
// - Monitor select in bits 7..4; 0000 leaves receiver 1 normal.
// - Codes 0001..0111 monitor receivers 2..8 on channel 1.
// - Code 1000 leaves transmitter 1 normal, nothing monitored.
// - Codes 1001..1111 monitor transmitters 2..8 on channel 1.
// - Read-only channel flags; bit n set when channel n+1 interrupts.
// - Output pin drives its level bit.
// - Input pin's level bit reads the pin.
// - Direction bit 0 output, 1 input; both reset to input.
// - Eight attenuator registers, spaced 0x20 from the first address.
// - Bit 5 selects wide bandwidth limit mode; resets zero.
// - Placement 01 transmit, 11 receive, 00 or 10 unused.
// - Depth 00 is 128, 01 is 64, 10/11 is 32 bits.
// - Bandwidth bit picks corner per line standard.
// - Global standard bit: 0 for E1, 1 for T1/J1.
// - Broadcast bit copies a channel write to all channels.
module lugj_regs
	import lugj_pkg::*;
#(
	parameter int CHANNELS = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [CHANNELS-1:0] chan_irq_pending,
	input wire logic spare_pin_a_in,
	input wire logic spare_pin_b_in,
	output logic spare_pin_a_out,
	output logic spare_pin_a_oe,
	output logic spare_pin_b_out,
	output logic spare_pin_b_oe,
	output lugj_watch_s watch_select,
	output logic line_standard_select,
	output lugj_atten_s [CHANNELS-1:0] atten_cfg
);

	generate
		if (CHANNELS != 8) begin : g_bad_channels
			$error("lugj_regs supports exactly eight channels");
		end
	endgenerate

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] global_r, global_nxt;
	logic [3:0] monitor_r, monitor_nxt;
	logic [1:0] pin_dir_r, pin_dir_nxt;
	logic [1:0] pin_level_r, pin_level_nxt;
	logic [7:0] irq_flags_r, irq_flags_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [5:0] atten_r [CHANNELS];
	logic [5:0] atten_nxt [CHANNELS];
	lugj_atten_s [CHANNELS-1:0] dec_w;
	lugj_atten_s [CHANNELS-1:0] atten_cfg_r;
	lugj_watch_s watch_nxt, watch_r;
	logic [1:0] pin_in_w;
	logic [2:0] chan_idx;
	logic chan_hit;
	logic [1:0] pin_out_nxt, pin_oe_nxt;

	assign pin_in_w = {spare_pin_b_in, spare_pin_a_in};
	assign chan_idx = reg_addr[7:5];
	assign chan_hit = (reg_addr[4:0] == LUGJ_ADR_ATTEN_BASE[4:0]);

	// ----------------------------------------
	// Per-channel attenuator registers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			always_comb begin
				atten_nxt[g] = atten_r[g];
				if (reg_write && chan_hit &&
					(chan_idx == 3'(g) || global_r[LUGJ_COPY_BIT])) begin
					atten_nxt[g] = reg_wdata[5:0];
				end
			end
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					atten_r[g] <= LUGJ_RST_ATTEN[5:0];
				end else begin
					atten_r[g] <= atten_nxt[g];
				end
			end
			lugj_atten_decode u_dec (
				.cfg({2'h0, atten_r[g]}),
				.t1_mode(global_r[LUGJ_STD_BIT]),
				.dec(dec_w[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Global configuration registers
	// ----------------------------------------
	always_comb begin
		global_nxt = global_r;
		monitor_nxt = monitor_r;
		pin_dir_nxt = pin_dir_r;
		pin_level_nxt = pin_level_r;
		if (reg_write) begin
			case (reg_addr)
				LUGJ_ADR_GLOBAL_CFG: global_nxt = reg_wdata;
				LUGJ_ADR_MONITOR: monitor_nxt = reg_wdata[7:4];
				LUGJ_ADR_PIN_CTRL: begin
					pin_dir_nxt[1] = reg_wdata[LUGJ_PIN_B_DIR_BIT];
					pin_dir_nxt[0] = reg_wdata[LUGJ_PIN_A_DIR_BIT];
					pin_level_nxt[1] = reg_wdata[LUGJ_PIN_B_LEVEL_BIT];
					pin_level_nxt[0] = reg_wdata[LUGJ_PIN_A_LEVEL_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			global_r <= LUGJ_RST_GLOBAL;
			monitor_r <= LUGJ_RST_MONITOR[7:4];
			pin_dir_r <= LUGJ_RST_PIN_DIR;
			pin_level_r <= LUGJ_RST_PIN_LEVEL;
		end else begin
			global_r <= global_nxt;
			monitor_r <= monitor_nxt;
			pin_dir_r <= pin_dir_nxt;
			pin_level_r <= pin_level_nxt;
		end
	end

	// ----------------------------------------
	// Channel interrupt flags
	// ----------------------------------------
	always_comb begin
		irq_flags_nxt = chan_irq_pending;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_flags_r <= 8'h00;
		end else begin
			irq_flags_r <= irq_flags_nxt;
		end
	end

	// ----------------------------------------
	// Monitor selection
	// ----------------------------------------
	always_comb begin
		watch_nxt.active = (monitor_r[2:0] != 3'h0);
		watch_nxt.is_tx = monitor_r[3];
		watch_nxt.chan = monitor_r[2:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			watch_r <= '0;
		end else begin
			watch_r <= watch_nxt;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_read) begin
			rdata_nxt = 8'h00;
			if (chan_hit) begin
				rdata_nxt = {2'h0, atten_r[chan_idx]};
			end else begin
				case (reg_addr)
					LUGJ_ADR_GLOBAL_CFG: rdata_nxt = global_r;
					LUGJ_ADR_MONITOR: rdata_nxt = {monitor_r, 4'h0};
					LUGJ_ADR_IRQ_FLAGS: rdata_nxt = irq_flags_r;
					LUGJ_ADR_PIN_CTRL: begin
						rdata_nxt = {4'h0, pin_level_r, pin_dir_r};
						if (pin_dir_r[0]) begin
							rdata_nxt[LUGJ_PIN_A_LEVEL_BIT] = pin_in_w[0];
						end
						if (pin_dir_r[1]) begin
							rdata_nxt[LUGJ_PIN_B_LEVEL_BIT] = pin_in_w[1];
						end
					end
					default: rdata_nxt = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	always_comb begin
		pin_out_nxt = pin_level_nxt;
		pin_oe_nxt = ~pin_dir_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			spare_pin_a_out <= 1'b0;
			spare_pin_a_oe <= 1'b0;
			spare_pin_b_out <= 1'b0;
			spare_pin_b_oe <= 1'b0;
		end else begin
			spare_pin_a_out <= pin_out_nxt[0];
			spare_pin_a_oe <= pin_oe_nxt[0];
			spare_pin_b_out <= pin_out_nxt[1];
			spare_pin_b_oe <= pin_oe_nxt[1];
		end
	end

	// ----------------------------------------
	// Decoded attenuator settings
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			atten_cfg_r <= '0;
		end else begin
			atten_cfg_r <= dec_w;
		end
	end

	assign reg_rdata = rdata_r;
	assign watch_select = watch_r;
	assign line_standard_select = global_r[LUGJ_STD_BIT];
	assign atten_cfg = atten_cfg_r;

endmodule

// ==== test/lugj_host.sv ====
`timescale 1ns/1ns
module lugj_host (
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = w;
		reg_read = !w;
		@(posedge clk_sys);
		#1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule

// ==== test/lugj_regs_sva.sv ====
`timescale 1ns/1ns
module lugj_regs_chk
	import lugj_pkg::*;
#(
	parameter int CHANNELS = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [CHANNELS-1:0] chan_irq_pending,
	input wire logic spare_pin_a_in,
	input wire logic spare_pin_a_out,
	input wire logic spare_pin_a_oe,
	input wire logic spare_pin_b_out,
	input wire logic spare_pin_b_oe,
	input wire lugj_watch_s watch_select,
	input wire lugj_atten_s [CHANNELS-1:0] atten_cfg
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	wire w_pin = reg_write && reg_addr == 8'hA0;
	wire w_att = reg_write && reg_addr == 8'h01;
	a_flags_read: assert property (reg_read && reg_addr == 8'h80 &&
		$stable(chan_irq_pending) |=> reg_rdata == $past(chan_irq_pending))
		else $error("flag read wrong");
	a_unmapped_zero: assert property (reg_read && reg_addr == 8'h05
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("read data moved");
	a_pin_a_drive: assert property (w_pin && !reg_wdata[0] |=>
		spare_pin_a_oe && spare_pin_a_out == $past(reg_wdata[2]))
		else $error("pin a drive wrong");
	a_pin_b_drive: assert property (w_pin && !reg_wdata[1] |=>
		spare_pin_b_oe && spare_pin_b_out == $past(reg_wdata[3]))
		else $error("pin b drive wrong");
	a_pin_input: assert property (w_pin && reg_wdata[0] |=>
		!spare_pin_a_oe) else $error("pin a still driven");
	a_pin_live: assert property (reg_read && reg_addr == 8'hA0 &&
		!spare_pin_a_oe |=> reg_rdata[2] == $past(spare_pin_a_in))
		else $error("pin a level read wrong");
	a_watch_code: assert property (reg_write && reg_addr == 8'h60
		|=> ##1 watch_select == {|$past(reg_wdata[6:4], 2),
		$past(reg_wdata[7:4], 2)}) else $error("watch select wrong");
	a_atten_place: assert property (w_att |=> ##1
		atten_cfg[0].in_tx == ($past(reg_wdata[4:3], 2) == 2'h1) &&
		atten_cfg[0].wide_limit == $past(reg_wdata[5], 2))
		else $error("placement wrong");
	a_atten_depth: assert property (w_att && reg_wdata[2:1] == 2'h0
		|=> ##1 atten_cfg[0].depth_bits == 8'h80)
		else $error("depth wrong");
endmodule
bind lugj_regs lugj_regs_chk #(.CHANNELS(CHANNELS)) u_chk (.clk_sys,
	.rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
	.chan_irq_pending, .spare_pin_a_in, .spare_pin_a_out, .spare_pin_a_oe,
	.spare_pin_b_out, .spare_pin_b_oe, .watch_select, .atten_cfg);

// ==== test/lugj_regs_test.sv ====
`timescale 1ns/1ns
module lugj_regs_test
	import lugj_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n, ext_a, ext_b, reg_write, reg_read;
	logic spare_pin_a_out, spare_pin_a_oe, spare_pin_b_out, spare_pin_b_oe;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, pend, a, d;
	lugj_watch_s watch_select;
	logic line_standard_select;
	lugj_atten_s [7:0] atten_cfg;
	logic [15:0] q[$];
	logic [15:0] note;
	int i, t, n_fail = 0, total_checks = 0;
	wire pin_a = spare_pin_a_oe ? spare_pin_a_out : ext_a;
	wire pin_b = spare_pin_b_oe ? spare_pin_b_out : ext_b;
	always #50 clk_sys = ~clk_sys;
	lugj_host u_lugj_host (.clk_sys, .reg_addr, .reg_wdata, .reg_write,
		.reg_read);
	lugj_regs #(.CHANNELS(8)) u_lugj_regs (.clk_sys, .rst_n, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.chan_irq_pending(pend), .spare_pin_a_in(pin_a),
		.spare_pin_b_in(pin_b), .spare_pin_a_out, .spare_pin_a_oe,
		.spare_pin_b_out, .spare_pin_b_oe, .watch_select,
		.line_standard_select, .atten_cfg);
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done();
		if (q.size() != 0)
			n_fail++;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		q.push_back({ad, e});
		u_lugj_host.acc(1'b0, ad, 8'h00);
	endtask
	task automatic wr_wait(input logic [7:0] ad, input logic [7:0] dt);
		u_lugj_host.acc(1'b1, ad, dt);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	function automatic lugj_atten_s dec(input logic [7:0] c, input logic s);
		dec.in_tx = c[4:3] == 2'h1;
		dec.in_rx = c[4:3] == 2'h3;
		dec.depth_bits = c[2:1] == 2'h0 ? LUGJ_DEPTH_128 :
			c[2:1] == 2'h1 ? LUGJ_DEPTH_64 : LUGJ_DEPTH_32;
		dec.wide_limit = c[5];
		dec.corner = c[0] ? (s ? LUGJ_CORNER_1P25HZ : LUGJ_CORNER_0P9HZ) :
			(s ? LUGJ_CORNER_5HZ : LUGJ_CORNER_6P8HZ);
	endfunction
	// ----------------------------------------
	// Read checker
	// ----------------------------------------
	always begin
		@(posedge clk_sys);
		if (reg_read === 1'b1) begin
			@(negedge clk_sys);
			if (q.size() == 0) begin
				chk("read queue", 16'h0, 16'hFFFF);
			end else begin
				note = q.pop_front();
				chk($sformatf("read %h", note[15:8]), note,
					{note[15:8], reg_rdata});
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		test_done();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		pend = 8'h00;
		ext_a = 1'b0;
		ext_b = 1'b0;
		void'($urandom(32'h7704));
		repeat (5) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		rd(8'h60, 8'h00);
		rd(8'h80, 8'h00);
		rd(8'hA0, 8'h03);
		rd(8'h01, 8'h00);
		rd(8'h05, 8'h00);
		chk("pin oe", 16'h0, 16'({spare_pin_a_oe, spare_pin_b_oe}));
		for (i = 0; i < 16; i++) begin
			d = {i[3:0], 4'($urandom())};
			wr_wait(8'h60, d);
			chk("watch", 16'({i[2:0] != 3'h0, i[3:0]}),
				16'(watch_select));
			rd(8'h60, {d[7:4], 4'h0});
		end
		for (t = 0; t < 2; t++) begin
			wr_wait(8'h40, {3'h0, t[0], 4'h0});
			chk("standard", 16'(t[0]), 16'(line_standard_select));
			for (i = 0; i < 8; i++) begin
				d = 8'($urandom());
				a = 8'h01 + 8'(i * 32);
				wr_wait(a, d);
				chk("atten", 16'(dec(d, t[0])),
					16'(atten_cfg[i]));
				rd(a, {2'h0, d[5:0]});
			end
		end
		wr_wait(8'h40, 8'h08);
		wr_wait(8'h61, 8'h2B);
		for (i = 0; i < 8; i++)
			rd(8'h01 + 8'(i * 32), 8'h2B);
		wr_wait(8'h40, 8'h00);
		wr_wait(8'h01, 8'h18);
		chk("depth", 16'(dec(8'h18, 1'b0)), 16'(atten_cfg[0]));
		rd(8'h01, 8'h18);
		pend = 8'($urandom());
		rd(8'h80, pend);
		wr_wait(8'h80, ~pend);
		rd(8'h80, pend);
		pend = 8'h00;
		rd(8'h80, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr_wait(8'hA0, {4'h0, i[1:0], 2'h0});
			chk("pin out", 16'({2'h3, i[1:0]}), 16'({spare_pin_b_oe,
				spare_pin_a_oe, spare_pin_b_out, spare_pin_a_out}));
			rd(8'hA0, {4'h0, i[1:0], 2'h0});
			ext_a = 1'($urandom());
			ext_b = 1'($urandom());
			wr_wait(8'hA0, 8'h0F);
			rd(8'hA0, {4'h0, ext_b, ext_a, 2'h3});
		end
		repeat (3) @(posedge clk_sys);
		test_done();
	end
endmodule
